/* core/sbap_pkg.sv */
// Constants, register map and initiator table of the system bus arbiter.
package sbap_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_INIT = 11;
  localparam int NUM_REGION = 14;
  localparam int NUM_GROUP = 4;
  localparam int IDX_W = 4;
  localparam int GRP_W = 2;
  localparam int REGION_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // Physical initiator ports
  // ---------------------------------------------------------------
  localparam int INIT_PROC = 0;
  localparam int INIT_DMA_RD = 1;
  localparam int INIT_DMA_WR = 2;
  localparam int INIT_USB = 3;
  localparam int INIT_ETH_RD = 4;
  localparam int INIT_ETH_WR = 5;
  localparam int INIT_CAN1 = 6;
  localparam int INIT_CAN2 = 7;
  localparam int INIT_SQI = 8;
  localparam int INIT_FLASH = 9;
  localparam int INIT_CRYPTO = 10;

  // ---------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_GROUP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_UNLOCK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_REGION_BASE = 8'h10;
  localparam int BIT_DMA_PRI = 25;
  localparam int BIT_PROC_PRI = 24;
  localparam int BIT_LOCK = 11;
  localparam int STAT_UNLOCKED_BIT = 8;
  localparam int STAT_HIGH_BIT = 9;
  localparam int GROUP_FIELD_W = NUM_INIT * GRP_W;
  // Unlock keys, values arbitrary
  localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 32'h1234_5678;
  localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 32'h8765_4321;
  // Reset values: every group may reach every region
  localparam logic [NUM_GROUP-1:0] REGION_RESET = 4'hF;
  localparam logic [GROUP_FIELD_W-1:0] GROUP_RESET = 22'h00_0000;

  // ---------------------------------------------------------------
  // Identifiers per policy
  // ---------------------------------------------------------------
  function automatic logic [3:0] sbap_id(input int idx, input logic high);
    logic [3:0] id;
    id = 4'h0;
    case (idx)
      INIT_PROC: id = high ? 4'h2 : 4'h1;
      INIT_DMA_RD: id = high ? 4'h4 : 4'h3;
      INIT_DMA_WR: id = high ? 4'h6 : 4'h5;
      INIT_USB: id = 4'h7;
      INIT_ETH_RD: id = 4'h8;
      INIT_ETH_WR: id = 4'h9;
      INIT_CAN1: id = 4'hA;
      INIT_CAN2: id = 4'hB;
      INIT_SQI: id = 4'hC;
      INIT_FLASH: id = 4'hD;
      INIT_CRYPTO: id = 4'hE;
      default: id = 4'h0;
    endcase
    return id;
  endfunction

endpackage

/* core/sbap_arbiter.sv */
// System bus arbiter with permission groups and lockable region control.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Contract
// - Least recently serviced order is default policy
// - High priority beats every least recent requester
// - Fixed identifiers per initiator and policy
// - DMA SRAM priority select at bit 25
// - Processor SRAM priority when exception flag set
// - Fourteen independently protected target regions
// - Each initiator assigned to one of four permission groups
// - Lock bit 11 blocks permission register writes
// - Lock bit changes need unlock sequence first
module sbap_arbiter
  import sbap_pkg::*;
#(
  parameter int SRAM_REGION = 0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_INIT-1:0] init_req,
  input wire logic [NUM_INIT*REGION_W-1:0] init_region,
  input wire logic exception_level_flag,
  output logic [NUM_INIT-1:0] grant,
  output logic [3:0] grant_id,
  output logic grant_high,
  output logic [NUM_INIT-1:0] deny
);

  // ---------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------
  logic dma_sram_priority_sel_reg, dma_sram_priority_sel_next;
  logic proc_sram_priority_sel_reg, proc_sram_priority_sel_next;
  logic permission_lock_bit_reg, permission_lock_bit_next;
  logic [GROUP_FIELD_W-1:0] group_assign_reg, group_assign_next;
  logic [NUM_GROUP-1:0] region_perm_reg [NUM_REGION];
  logic [NUM_GROUP-1:0] region_perm_next [NUM_REGION];
  logic key_stage_reg, key_stage_next;
  logic unlocked_reg, unlocked_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  // ---------------------------------------------------------------
  // Arbiter state
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] order_reg [NUM_INIT];
  logic [IDX_W-1:0] order_next [NUM_INIT];
  logic [NUM_INIT-1:0] grant_reg, grant_next;
  logic [NUM_INIT-1:0] deny_reg, deny_next;
  logic [3:0] grant_id_reg, grant_id_next;
  logic grant_high_reg, grant_high_next;
  logic [3:0] last_id_reg, last_id_next;

  // Region register hit for an address
  function automatic logic region_hit(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFF_REGION_BASE;
    return (addr >= OFF_REGION_BASE) && (rel[1:0] == 2'b00) &&
           (rel[ADDR_W-1:2] < NUM_REGION[ADDR_W-3:0]);
  endfunction

  // Region index of an address already known to hit
  function automatic int region_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFF_REGION_BASE;
    return int'(rel[ADDR_W-1:2]);
  endfunction

  // ---------------------------------------------------------------
  // Register writes, unlock sequence and reads
  // ---------------------------------------------------------------
  always_comb begin
    dma_sram_priority_sel_next = dma_sram_priority_sel_reg;
    proc_sram_priority_sel_next = proc_sram_priority_sel_reg;
    permission_lock_bit_next = permission_lock_bit_reg;
    group_assign_next = group_assign_reg;
    region_perm_next = region_perm_reg;
    key_stage_next = key_stage_reg;
    unlocked_next = unlocked_reg;
    rdata_next = '0;
    if (reg_wr) begin
      // Any write breaks a half-done key sequence
      key_stage_next = 1'b0;
      if (reg_addr == OFF_CONFIG) begin
        dma_sram_priority_sel_next = reg_wdata[BIT_DMA_PRI];
        proc_sram_priority_sel_next = reg_wdata[BIT_PROC_PRI];
        if (unlocked_reg) begin
          permission_lock_bit_next = reg_wdata[BIT_LOCK];
        end
        // One unlock buys one config write, so a stray write cannot relock later
        unlocked_next = 1'b0;
      end else if (reg_addr == OFF_GROUP) begin
        if (!permission_lock_bit_reg) begin
          group_assign_next = reg_wdata[GROUP_FIELD_W-1:0];
        end
      end else if (reg_addr == OFF_UNLOCK) begin
        if (reg_wdata == UNLOCK_KEY1) begin
          key_stage_next = 1'b1;
        end else if (key_stage_reg && (reg_wdata == UNLOCK_KEY2)) begin
          unlocked_next = 1'b1;
        end
      end else if (region_hit(reg_addr)) begin
        if (!permission_lock_bit_reg) begin
          region_perm_next[region_index(reg_addr)] = reg_wdata[NUM_GROUP-1:0];
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == OFF_CONFIG) begin
        rdata_next[BIT_DMA_PRI] = dma_sram_priority_sel_reg;
        rdata_next[BIT_PROC_PRI] = proc_sram_priority_sel_reg;
        rdata_next[BIT_LOCK] = permission_lock_bit_reg;
      end else if (reg_addr == OFF_GROUP) begin
        rdata_next[GROUP_FIELD_W-1:0] = group_assign_reg;
      end else if (reg_addr == OFF_STATUS) begin
        rdata_next[3:0] = last_id_reg;
        rdata_next[STAT_UNLOCKED_BIT] = unlocked_reg;
        rdata_next[STAT_HIGH_BIT] = grant_high_reg;
      end else if (region_hit(reg_addr)) begin
        rdata_next[NUM_GROUP-1:0] = region_perm_reg[region_index(reg_addr)];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_sram_priority_sel_reg <= 1'b0;
      proc_sram_priority_sel_reg <= 1'b0;
      permission_lock_bit_reg <= 1'b0;
      group_assign_reg <= GROUP_RESET;
      for (int r = 0; r < NUM_REGION; r++) begin
        region_perm_reg[r] <= REGION_RESET;
      end
      key_stage_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      dma_sram_priority_sel_reg <= dma_sram_priority_sel_next;
      proc_sram_priority_sel_reg <= proc_sram_priority_sel_next;
      permission_lock_bit_reg <= permission_lock_bit_next;
      group_assign_reg <= group_assign_next;
      region_perm_reg <= region_perm_next;
      key_stage_reg <= key_stage_next;
      unlocked_reg <= unlocked_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Permission check, policy select and least recent pick
  // ---------------------------------------------------------------
  always_comb begin
    logic [NUM_INIT-1:0] permit;
    logic [NUM_INIT-1:0] high;
    logic [NUM_INIT-1:0] eligible;
    logic [NUM_INIT-1:0] cls;
    logic [GRP_W-1:0] grp;
    logic [REGION_W-1:0] rgn;
    logic sram;
    logic found;
    int win_pos;
    int win_idx;
    permit = '0;
    high = '0;
    eligible = '0;
    cls = '0;
    grp = '0;
    rgn = '0;
    sram = 1'b0;
    found = 1'b0;
    win_pos = 0;
    win_idx = 0;
    for (int i = 0; i < NUM_INIT; i++) begin
      grp = group_assign_reg[i*GRP_W +: GRP_W];
      rgn = init_region[i*REGION_W +: REGION_W];
      // Region numbers past the last one map to nothing and are refused
      if (rgn < NUM_REGION[REGION_W-1:0]) begin
        permit[i] = region_perm_reg[rgn][grp];
      end
      sram = (rgn == SRAM_REGION[REGION_W-1:0]);
      if (i == INIT_FLASH) begin
        high[i] = 1'b1;
      end else if ((i == INIT_DMA_RD) || (i == INIT_DMA_WR)) begin
        high[i] = dma_sram_priority_sel_reg && sram;
      end else if (i == INIT_PROC) begin
        high[i] = proc_sram_priority_sel_reg && exception_level_flag && sram;
      end
    end
    // Masking last cycle's answers gives the requester a cycle to drop its request
    eligible = init_req & permit & ~grant_reg;
    deny_next = init_req & ~permit & ~deny_reg;
    // High class starves the rest whenever it asks
    cls = (|(eligible & high)) ? (eligible & high) : eligible;
    for (int k = 0; k < NUM_INIT; k++) begin
      if (!found && cls[order_reg[k]]) begin
        found = 1'b1;
        win_pos = k;
        win_idx = int'(order_reg[k]);
      end
    end
    order_next = order_reg;
    grant_next = '0;
    grant_id_next = 4'h0;
    grant_high_next = 1'b0;
    last_id_next = last_id_reg;
    if (found) begin
      // Winner moves to the back, so it is now the most recently served
      for (int k = 0; k < NUM_INIT - 1; k++) begin
        if (k >= win_pos) begin
          order_next[k] = order_reg[k+1];
        end
      end
      order_next[NUM_INIT-1] = IDX_W'(win_idx);
      grant_next[win_idx] = 1'b1;
      grant_high_next = high[win_idx];
      grant_id_next = sbap_id(win_idx, high[win_idx]);
      last_id_next = sbap_id(win_idx, high[win_idx]);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NUM_INIT; k++) begin
        order_reg[k] <= IDX_W'(k);
      end
      grant_reg <= '0;
      deny_reg <= '0;
      grant_id_reg <= 4'h0;
      grant_high_reg <= 1'b0;
      last_id_reg <= 4'h0;
    end else begin
      order_reg <= order_next;
      grant_reg <= grant_next;
      deny_reg <= deny_next;
      grant_id_reg <= grant_id_next;
      grant_high_reg <= grant_high_next;
      last_id_reg <= last_id_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign grant = grant_reg;
  assign grant_id = grant_id_reg;
  assign grant_high = grant_high_reg;
  assign deny = deny_reg;

endmodule // sbap_arbiter

/* dv/sbap_checker.sv */
// Checker: concurrent assertions on the arbiter ports
`timescale 1ns/1ps
module sbap_checker
  import sbap_pkg::*;
#(
  parameter int SRAM_REGION = 0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_INIT-1:0] init_req,
  input wire logic [NUM_INIT*REGION_W-1:0] init_region,
  input wire logic exception_level_flag,
  input wire logic [NUM_INIT-1:0] grant,
  input wire logic [3:0] grant_id,
  input wire logic grant_high,
  input wire logic [NUM_INIT-1:0] deny
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Usb waiting, then answered unless high class cut in
  sequence s_usb_wait;
    init_req[3] && !grant[3] && !deny[3];
  endsequence
  sequence s_usb_done;
    ##[1:12] (grant[3] || deny[3] || grant_high);
  endsequence
  a_grant_onehot: assert property ($onehot0(grant)) else $error("grant not one-hot");
  a_usb_served: assert property (s_usb_wait |-> s_usb_done) else $error("usb starved");
  a_high_first: assert property (grant != '0 && !grant_high |->
    !$past(init_req[9] && !grant[9] && !deny[9]) || deny[9]) else $error("flash lost");
  a_flash_id: assert property (grant[9] |-> grant_id == 4'hD && grant_high) else $error("flash id");
  a_usb_id: assert property (grant[3] |-> grant_id == 4'h7 && !grant_high) else $error("usb id");
  a_dma_id: assert property (grant[1] |-> grant_id == (grant_high ? 4'h4 : 4'h3))
    else $error("dma id");
  a_dma_sram: assert property (grant[1] && grant_high |-> $past(init_region[7:4]) == SRAM_REGION)
    else $error("dma high off sram");
  a_proc_exl: assert property (grant[0] && grant_high |-> $past(exception_level_flag)
    && grant_id == 4'h2) else $error("proc high without flag");
  a_bad_region: assert property (s_usb_wait ##0 (init_region[15:12] >= 4'hE) |=> deny[3] && !grant[3])
    else $error("no-region not denied");
  a_key_hidden: assert property (reg_rd && reg_addr == OFF_UNLOCK |=> reg_rdata == '0)
    else $error("key readable");
endmodule // sbap_checker
bind sbap_arbiter sbap_checker #(.SRAM_REGION(SRAM_REGION)) i_sbap_checker (.clock, .nrst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .init_req, .init_region,
  .exception_level_flag, .grant, .grant_id, .grant_high, .deny);

/* dv/sbap_initiators.sv */
// Model of the bus initiators: each request holds until answered
`timescale 1ns/1ps
module sbap_initiators
  import sbap_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [NUM_INIT-1:0] go,
  input wire logic [NUM_INIT-1:0] grant,
  input wire logic [NUM_INIT-1:0] deny,
  output logic [NUM_INIT-1:0] init_req
);
  logic [NUM_INIT-1:0] req_reg;
  logic [NUM_INIT-1:0] req_next;
  // One short request per go keeps high-priority load light
  always_comb begin
    req_next = (req_reg | go) & ~(grant | deny);
  end
  // Request state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end
  assign init_req = req_reg;
endmodule // sbap_initiators

/* dv/tb_top.sv */
// Testbench: registers, arbitration order, permissions and lock
`timescale 1ns/1ps
module tb_top;
  import sbap_pkg::*;
  logic clock = 0;
  logic nrst = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic rd_d = 0;
  logic exception_level_flag = 0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_INIT-1:0] go = '0;
  logic [NUM_INIT-1:0] init_req, grant, deny;
  logic [NUM_INIT*REGION_W-1:0] init_region = '0;
  logic [3:0] grant_id;
  logic grant_high;
  logic [31:0] seed = 32'h0000_94B0;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] qg[$];
  logic [31:0] qr[$];
  int ord[$];
  always #20 clock = ~clock;
  sbap_arbiter i_sbap_arbiter (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .init_req, .init_region, .exception_level_flag, .grant, .grant_id,
    .grant_high, .deny);
  sbap_initiators i_sbap_initiators (.clock, .nrst, .go, .grant, .deny, .init_req);
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] eid(input int i, input logic h);
    return (i < 3) ? 4'(2 * i + 1 + h) : 4'(i + 4);
  endfunction
  task check(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    reg_rd <= 0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    qr.push_back(e);
    reg_addr <= a;
    reg_wr <= 0;
    reg_rd <= 1;
    @(posedge clock);
  endtask
  // Notes the grant order from a model of the service order, then fires
  task automatic round(input logic [10:0] s, input logic [10:0] hi, input logic [10:0] dn);
    int w[$];
    int k;
    foreach (ord[j]) if (s[ord[j]] && hi[ord[j]]) w.push_back(ord[j]);
    foreach (ord[j]) if (s[ord[j]] && !hi[ord[j]]) w.push_back(ord[j]);
    foreach (w[j]) begin
      qg.push_back({4'(w[j]), eid(w[j], hi[w[j]])});
      ord = ord.find(x) with (x != w[j]);
      ord.push_back(w[j]);
    end
    for (k = 0; k < 11; k++) if (dn[k]) qg.push_back({4'(k), 4'hF});
    reg_wr <= 0;
    reg_rd <= 0;
    go <= s | dn;
    @(posedge clock);
    go <= '0;
    for (k = 0; k < 40 && qg.size() != 0; k++) @(posedge clock);
    @(posedge clock);
  endtask
  task finish_test;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Monitor: results one edge late, compared with the oldest note
  always @(posedge clock) begin
    cyc++;
    rd_d <= reg_rd;
    if (rd_d) check("rdata", qr.pop_front(), reg_rdata);
    for (int i = 0; i < 11; i++) if (grant[i]) check("grant", qg.pop_front(), {i[3:0], grant_id});
    for (int i = 0; i < 11; i++) if (deny[i]) check("deny", qg.pop_front(), {i[3:0], 4'hF});
    if (cyc > 3000) begin
      errors++;
      finish_test();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    ord = {0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};
    repeat (3) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    rd(OFF_CONFIG, 0);
    rd(OFF_GROUP, 0);
    rd(OFF_REGION_BASE + 8'h34, 32'(REGION_RESET));
    rd(8'h80, 0);
    round(0, 0, 0);
    $display("test reset_values done");
    round(11'(xs()) | 11'h001, 11'h200, 0);
    round(11'h7FF, 11'h200, 0);
    $display("test lrs_order done");
    wr(OFF_CONFIG, 32'h0200_0000);
    round(11'h00E, 11'h006, 0);
    wr(OFF_CONFIG, 32'h0100_0000);
    exception_level_flag <= 1;
    round(11'h009, 11'h001, 0);
    exception_level_flag <= 0;
    round(11'h009, 0, 0);
    $display("test high_policy done");
    wr(OFF_REGION_BASE + 8'h04, 32'h2);
    wr(OFF_GROUP, 32'h0000_0100);
    init_region[19:12] <= 8'h11;
    round(11'h010, 0, 11'h008);
    init_region[15:12] <= 4'hE + 4'(xs() & 1);
    round(0, 0, 11'h008);
    $display("test permissions done");
    wr(OFF_CONFIG, 32'h800);
    rd(OFF_CONFIG, 0);
    // A stray write between the keys must leave the bank locked
    wr(OFF_UNLOCK, UNLOCK_KEY1);
    wr(8'h80, 32'h0000_0000);
    wr(OFF_UNLOCK, UNLOCK_KEY2);
    rd(OFF_STATUS, 32'h0000_0008);
    wr(OFF_UNLOCK, UNLOCK_KEY1);
    wr(OFF_UNLOCK, UNLOCK_KEY2);
    // Unlocked flag up, last id still the earlier grant; key never reads back
    rd(OFF_STATUS, 32'h0000_0108);
    rd(OFF_UNLOCK, 32'h0000_0000);
    wr(OFF_CONFIG, 32'h800);
    rd(OFF_CONFIG, 32'h800);
    wr(OFF_GROUP, 0);
    rd(OFF_GROUP, 32'h100);
    wr(OFF_REGION_BASE + 8'h04, 32'hF);
    rd(OFF_REGION_BASE + 8'h04, 32'h2);
    wr(OFF_CONFIG, 0);
    rd(OFF_CONFIG, 32'h800);
    round(0, 0, 0);
    $display("test lock done");
    finish_test();
  end
endmodule // tb_top
